// [verilog/mpu_cfg_pkg.sv]
// Constants, field layouts and carriers for the region configuration bank.
// Assumes a 32-bit classic Wishbone register bus on a single clock.
package mpu_cfg_pkg;

  // ==========================================================================
  // Geometry
  localparam int          REGION_COUNT   = 8;
  localparam int          REGION_IDX_W   = 3;
  localparam int          BASE_LSB       = 5;
  localparam logic [31:0] TYPE_VALUE     = 32'h0000_0800;

  // ==========================================================================
  // Byte addresses
  localparam logic [31:0] ADR_TYPE       = 32'hE000_ED90;
  localparam logic [31:0] ADR_SELECT     = 32'hE000_ED98;
  localparam logic [31:0] ADR_BASE       = 32'hE000_ED9C;
  localparam logic [31:0] ADR_ATTR       = 32'hE000_EDA0;
  localparam logic [31:0] ADR_BASE_A1    = 32'hE000_EDA4;
  localparam logic [31:0] ADR_ATTR_A1    = 32'hE000_EDA8;

  // ==========================================================================
  // Field positions
  localparam int          BASE_VALID_BIT = 4;
  localparam int          BASE_REGION_W  = 4;
  localparam int          ATTR_FD_BIT    = 28;
  localparam int          ATTR_PERM_LSB  = 24;
  localparam int          ATTR_MT_LSB    = 19;
  localparam int          ATTR_SH_BIT    = 18;
  localparam int          ATTR_CA_BIT    = 17;
  localparam int          ATTR_BU_BIT    = 16;
  localparam int          ATTR_SUBD_LSB  = 8;
  localparam int          ATTR_SIZE_LSB  = 1;
  localparam int          ATTR_EN_BIT    = 0;
  localparam logic [4:0]  SIZE_MIN       = 5'h04;
  localparam logic [4:0]  SIZE_MAX       = 5'h1F;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic       fetch_disable_bit;
    logic [2:0] access_perm_field;
    logic [2:0] memory_type_field;
    logic       shareable;
    logic       cacheable;
    logic       bufferable;
    logic [7:0] subregion_disable_mask;
    logic [4:0] size;
    logic       enable;
  } attr_s;

  typedef struct packed {
    logic [31:0] base;
    attr_s       attr;
  } region_cfg_s;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [31:0] adr;
    logic [31:0] dat;
  } wb_req_s;

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] attr_pack(input attr_s a);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ATTR_FD_BIT] = a.fetch_disable_bit;
    w[ATTR_PERM_LSB +: 3] = a.access_perm_field;
    w[ATTR_MT_LSB +: 3] = a.memory_type_field;
    w[ATTR_SH_BIT] = a.shareable;
    w[ATTR_CA_BIT] = a.cacheable;
    w[ATTR_BU_BIT] = a.bufferable;
    w[ATTR_SUBD_LSB +: 8] = a.subregion_disable_mask;
    w[ATTR_SIZE_LSB +: 5] = a.size;
    w[ATTR_EN_BIT] = a.enable;
    return w;
  endfunction : attr_pack

  function automatic attr_s attr_unpack(input logic [31:0] w);
    attr_s a;
    a.fetch_disable_bit = w[ATTR_FD_BIT];
    a.access_perm_field = w[ATTR_PERM_LSB +: 3];
    a.memory_type_field = w[ATTR_MT_LSB +: 3];
    a.shareable = w[ATTR_SH_BIT];
    a.cacheable = w[ATTR_CA_BIT];
    a.bufferable = w[ATTR_BU_BIT];
    a.subregion_disable_mask = w[ATTR_SUBD_LSB +: 8];
    a.size = w[ATTR_SIZE_LSB +: 5];
    a.enable = w[ATTR_EN_BIT];
    return a;
  endfunction : attr_unpack

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
                                              input logic [31:0] new_w,
                                              input logic [3:0]  sel);
    logic [31:0] w;
    w = old_w;
    for (int b = 0; b < 4; b++)
      if (sel[b])
        w[b*8 +: 8] = new_w[b*8 +: 8];
    return w;
  endfunction : merge_bytes

endpackage : mpu_cfg_pkg

// [verilog/base_mask.sv]
// Address mask of the bits that form the base field for a given size code.
// Pure combinational; no clock.
`timescale 1ns/100ps
module base_mask
(
  // Size code
  input  wire logic [4:0]  size_i,
  // Mask, ones from bit size+1 upward
  output logic      [31:0] mask_o
);

  // ==========================================================================
  // One bit per address position
  for (genvar i = 0; i < 32; i++)
  begin : g_bit
    assign mask_o[i] = (i > int'(size_i));
  end

endmodule : base_mask

// [verilog/region_store.sv]
// Per-region base and attribute storage, written one region at a time.
// Assumes the caller has already masked and merged the write data.
`timescale 1ns/100ps
module region_store
#(
  parameter int REGIONS = mpu_cfg_pkg::REGION_COUNT,
  parameter int IDX_W   = mpu_cfg_pkg::REGION_IDX_W
)
(
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // Write port
  input  wire logic                       base_we_i,
  input  wire logic                       attr_we_i,
  input  wire logic [IDX_W-1:0]           base_idx_i,
  input  wire logic [IDX_W-1:0]           attr_idx_i,
  input  wire logic [31:0]                base_wdata_i,
  input  mpu_cfg_pkg::attr_s              attr_wdata_i,
  // Stored values
  output logic [REGIONS-1:0][31:0]        base_o,
  output mpu_cfg_pkg::attr_s [REGIONS-1:0] attr_o
);

  // ==========================================================================
  // Storage, one entry per region
  for (genvar r = 0; r < REGIONS; r++)
  begin : g_region
    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        base_o[r] <= 32'h0000_0000;
      else if (base_we_i && (base_idx_i == IDX_W'(r)))
        base_o[r] <= base_wdata_i;
    end

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
        attr_o[r] <= '0;
      else if (attr_we_i && (attr_idx_i == IDX_W'(r)))
        attr_o[r] <= attr_wdata_i;
    end
  end

endmodule : region_store

// [verilog/mpu_region_config_bank.sv]
// Region programming bank of a memory protection unit: region select,
// base address and attribute/size registers plus their first alias pair.
// Assumes a classic Wishbone master on clk_i and synchronous reset.
//
// Summary of operation
// - Eight regions; select accepts only 0 to 7.
// - Valid base write to region 0 to 7 copies region, writes there; higher region is dropped.
// - Invalid base write keeps select, writes current.
// - Base valid bit always reads zero.
// - Base region field reads current select.
// - Base field is bits 31 down to N.
// - 4 GB region has no base, base zero.
// - Attribute register takes word and halfword accesses.
// - Bit 28 disables instruction fetch from region.
// - Each mask bit disables one subregion.
// - Region bytes equal two to size plus one.
// - Sizes range from 32 bytes to 4 GB.
// - Region active only while enable bit set.
// - Size and attributes stored per region.
// - Alias pair behaves as primary pair.
// - Type register reports eight unified regions.
`timescale 1ns/100ps
module mpu_region_config_bank
#(
  parameter int REGIONS = mpu_cfg_pkg::REGION_COUNT,
  parameter int IDX_W   = mpu_cfg_pkg::REGION_IDX_W
)
(
  // Clock and reset
  input  wire logic                               clk_i,
  input  wire logic                               rst_i,
  // Wishbone slave
  input  mpu_cfg_pkg::wb_req_s                    wb_req_i,
  output logic                                    wb_ack_o,
  output logic [31:0]                             wb_dat_o,
  // Region configuration towards the protection checker
  output mpu_cfg_pkg::region_cfg_s [REGIONS-1:0]  region_cfg_o,
  output logic [REGIONS-1:0]                      region_active_o
);

  // ==========================================================================
  // Declarations
  localparam int BASE_W = mpu_cfg_pkg::BASE_REGION_W;
  logic [IDX_W-1:0]                region_select;
  logic                            req;
  logic                            take;
  logic                            hit_type;
  logic                            hit_select;
  logic                            hit_base;
  logic                            hit_attr;
  logic                            base_valid;
  logic [BASE_W-1:0]               base_region;
  logic                            base_region_ok;
  logic                            base_we;
  logic                            attr_we;
  logic                            select_we;
  logic [IDX_W-1:0]                base_idx;
  logic [31:0]                     base_wdata;
  mpu_cfg_pkg::attr_s              attr_wdata;
  logic [31:0]                     attr_merged;
  logic [REGIONS-1:0][31:0]        base_raw;
  mpu_cfg_pkg::attr_s [REGIONS-1:0] attr_raw;
  logic [REGIONS-1:0][31:0]        mask;
  logic [31:0]                     next_dat;

  // ==========================================================================
  // Bus decode
  assign req        = wb_req_i.cyc && wb_req_i.stb;
  assign take       = req && !wb_ack_o;
  assign hit_type   = (wb_req_i.adr == mpu_cfg_pkg::ADR_TYPE);
  assign hit_select = (wb_req_i.adr == mpu_cfg_pkg::ADR_SELECT);
  assign hit_base   = (wb_req_i.adr == mpu_cfg_pkg::ADR_BASE)
                   || (wb_req_i.adr == mpu_cfg_pkg::ADR_BASE_A1);
  assign hit_attr   = (wb_req_i.adr == mpu_cfg_pkg::ADR_ATTR)
                   || (wb_req_i.adr == mpu_cfg_pkg::ADR_ATTR_A1);

  // ==========================================================================
  // Base write path
  assign base_valid     = wb_req_i.dat[mpu_cfg_pkg::BASE_VALID_BIT] && wb_req_i.sel[0];
  assign base_region    = wb_req_i.dat[BASE_W-1:0];
  assign base_region_ok = (base_region < BASE_W'(REGIONS));
  assign base_idx       = base_valid ? base_region[IDX_W-1:0] : region_select;
  assign base_we        = take && wb_req_i.we && hit_base
                       && (!base_valid || base_region_ok);
  assign select_we      = take && wb_req_i.we && hit_select && wb_req_i.sel[0]
                       && (wb_req_i.dat[7:0] < 8'(REGIONS));

  // Unaligned low bits are dropped against the target region's size
  assign base_wdata = mpu_cfg_pkg::merge_bytes(base_raw[base_idx], wb_req_i.dat,
                                               wb_req_i.sel)
                    & mask[base_idx];

  // ==========================================================================
  // Attribute write path
  assign attr_we     = take && wb_req_i.we && hit_attr;
  assign attr_merged = mpu_cfg_pkg::merge_bytes(mpu_cfg_pkg::attr_pack(attr_raw[region_select]),
                                                wb_req_i.dat, wb_req_i.sel);

  always_comb
  begin
    attr_wdata = mpu_cfg_pkg::attr_unpack(attr_merged);
    if (wb_req_i.sel[0] && (attr_wdata.size < mpu_cfg_pkg::SIZE_MIN))
      attr_wdata.size = mpu_cfg_pkg::SIZE_MIN;
  end

  // ==========================================================================
  // Region select
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      region_select <= '0;
    else if (base_we && base_valid)
      region_select <= base_region[IDX_W-1:0];
    else if (select_we)
      region_select <= wb_req_i.dat[IDX_W-1:0];
  end

  // ==========================================================================
  // Storage and masks
  region_store #(
    .REGIONS      (REGIONS),
    .IDX_W        (IDX_W)
  ) u_store (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .base_we_i    (base_we),
    .attr_we_i    (attr_we),
    .base_idx_i   (base_idx),
    .attr_idx_i   (region_select),
    .base_wdata_i (base_wdata),
    .attr_wdata_i (attr_wdata),
    .base_o       (base_raw),
    .attr_o       (attr_raw)
  );

  for (genvar r = 0; r < REGIONS; r++)
  begin : g_mask
    base_mask u_mask (
      .size_i (attr_raw[r].size),
      .mask_o (mask[r])
    );

    always_ff @(posedge clk_i)
    begin
      if (rst_i)
      begin
        region_cfg_o[r]    <= '0;
        region_active_o[r] <= 1'b0;
      end
      else
      begin
        region_cfg_o[r].base <= base_raw[r] & mask[r];
        region_cfg_o[r].attr <= attr_raw[r];
        region_active_o[r]   <= attr_raw[r].enable;
      end
    end
  end

  // ==========================================================================
  // Read data
  always_comb
  begin
    next_dat = 32'h0000_0000;
    if (hit_type)
      next_dat = mpu_cfg_pkg::TYPE_VALUE;
    else if (hit_select)
      next_dat[IDX_W-1:0] = region_select;
    else if (hit_base)
    begin
      next_dat = base_raw[region_select] & mask[region_select];
      next_dat[BASE_W-1:0] = BASE_W'(region_select);
      next_dat[mpu_cfg_pkg::BASE_VALID_BIT] = 1'b0;
    end
    else if (hit_attr)
      next_dat = mpu_cfg_pkg::attr_pack(attr_raw[region_select]);
  end

  // ==========================================================================
  // Bus answer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= take;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      wb_dat_o <= 32'h0000_0000;
    else if (take && !wb_req_i.we)
      wb_dat_o <= next_dat;
  end

  // ==========================================================================
  // Assertions
  a_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");

  a_ack_after_req: assert property (@(posedge clk_i) disable iff (rst_i)
    take |=> wb_ack_o)
    else $error("request not answered in one cycle");

  a_select_out_range: assert property (@(posedge clk_i) disable iff (rst_i)
    take && wb_req_i.we && hit_select && (wb_req_i.dat[7:0] >= 8'(REGIONS))
    |=> $stable(region_select))
    else $error("out of range select accepted");

  a_valid_copies_region: assert property (@(posedge clk_i) disable iff (rst_i)
    take && wb_req_i.we && hit_base && base_valid && base_region_ok
    |=> region_select == $past(wb_req_i.dat[IDX_W-1:0]))
    else $error("valid base write did not move select");

  a_invalid_keeps_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    take && wb_req_i.we && hit_base && !base_valid
    |=> $stable(region_select))
    else $error("base write without valid moved select");

  a_valid_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_req_i.we && hit_base
    |-> !wb_dat_o[mpu_cfg_pkg::BASE_VALID_BIT])
    else $error("valid bit read as one");

  a_region_readback: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_req_i.we && hit_base
    |-> wb_dat_o[BASE_W-1:0] == BASE_W'(region_select))
    else $error("base read region differs from select");

  a_base_aligned: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_req_i.we && hit_base
    |-> (wb_dat_o[31:5] & ~mask[region_select][31:5]) == 27'h0000000)
    else $error("base read shows bits below N");

  a_full_map_base: assert property (@(posedge clk_i) disable iff (rst_i)
    attr_raw[region_select].size == mpu_cfg_pkg::SIZE_MAX
    |=> region_cfg_o[$past(region_select)].base == 32'h0000_0000)
    else $error("4 GB region has nonzero base");

  a_half_keeps_upper: assert property (@(posedge clk_i) disable iff (rst_i)
    attr_we && (wb_req_i.sel[3:2] == 2'b00)
    |=> attr_raw[$past(region_select)].fetch_disable_bit
        == $past(attr_raw[region_select].fetch_disable_bit))
    else $error("lower halfword write changed upper half");

  a_size_floor: assert property (@(posedge clk_i) disable iff (rst_i)
    attr_we && wb_req_i.sel[0]
    |=> attr_raw[$past(region_select)].size >= mpu_cfg_pkg::SIZE_MIN)
    else $error("size below minimum stored");

  a_enable_active: assert property (@(posedge clk_i) disable iff (rst_i)
    attr_we && wb_req_i.sel[0] && wb_req_i.dat[0]
    |=> ##1 region_active_o[$past(region_select, 2)])
    else $error("enabled region not active two cycles later");

  a_type_value: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_req_i.we && hit_type |-> wb_dat_o == 32'h0000_0800)
    else $error("type register value wrong");

  a_reset_clear: assert property (@(posedge clk_i)
    $past(rst_i) && !rst_i |-> (region_active_o == '0) && (region_select == '0))
    else $error("state not cleared by reset");

  a_select_write: assert property (@(posedge clk_i) disable iff (rst_i)
    select_we
    |=> region_select == $past(wb_req_i.dat[IDX_W-1:0]))
    else $error("select write not stored");

  a_base_range_drop: assert property (@(posedge clk_i) disable iff (rst_i)
    take && wb_req_i.we && hit_base && base_valid && !base_region_ok
    |=> $stable(base_raw) && $stable(region_select))
    else $error("out of range base write took effect");

  a_valid_base_store: assert property (@(posedge clk_i) disable iff (rst_i)
    take && wb_req_i.we && hit_base && base_valid && base_region_ok
    && (wb_req_i.sel == 4'hF)
    |=> base_raw[region_select]
        == $past(wb_req_i.dat & mask[base_region[IDX_W-1:0]]))
    else $error("valid base write missed its region");

  a_invalid_base_store: assert property (@(posedge clk_i) disable iff (rst_i)
    take && wb_req_i.we && hit_base && !base_valid && (wb_req_i.sel == 4'hF)
    |=> base_raw[$past(region_select)]
        == $past(wb_req_i.dat & mask[region_select]))
    else $error("plain base write missed selected region");

  a_full_map_read: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_req_i.we && hit_base
    && (attr_raw[region_select].size == mpu_cfg_pkg::SIZE_MAX)
    |-> wb_dat_o[31:5] == 27'h0000000)
    else $error("4 GB region read shows a base");

  a_upper_keeps_lower: assert property (@(posedge clk_i) disable iff (rst_i)
    attr_we && (wb_req_i.sel[1:0] == 2'b00)
    |=> attr_raw[$past(region_select)].size
        == $past(attr_raw[region_select].size))
    else $error("upper halfword write changed size");

  a_fetch_disable_out: assert property (@(posedge clk_i) disable iff (rst_i)
    attr_we && wb_req_i.sel[3]
    |=> ##1 region_cfg_o[$past(region_select, 2)].attr.fetch_disable_bit
        == $past(wb_req_i.dat[mpu_cfg_pkg::ATTR_FD_BIT], 2))
    else $error("fetch disable bit not passed out");

  a_subregion_out: assert property (@(posedge clk_i) disable iff (rst_i)
    attr_we && wb_req_i.sel[1]
    |=> ##1 region_cfg_o[$past(region_select, 2)].attr.subregion_disable_mask
        == $past(wb_req_i.dat[mpu_cfg_pkg::ATTR_SUBD_LSB +: 8], 2))
    else $error("subregion mask not passed out");

  a_mask_edge: assert property (@(posedge clk_i) disable iff (rst_i)
    attr_raw[region_select].size != mpu_cfg_pkg::SIZE_MAX
    |-> mask[region_select][attr_raw[region_select].size + 5'h01]
        && !mask[region_select][attr_raw[region_select].size])
    else $error("mask edge not at size plus one");

  a_active_follows: assert property (@(posedge clk_i) disable iff (rst_i)
    1'b1
    |=> region_active_o[$past(region_select)]
        == $past(attr_raw[region_select].enable))
    else $error("region active differs from enable");

  a_attr_word_store: assert property (@(posedge clk_i) disable iff (rst_i)
    attr_we && (wb_req_i.sel == 4'hF)
    && (wb_req_i.dat[mpu_cfg_pkg::ATTR_SIZE_LSB +: 5] >= mpu_cfg_pkg::SIZE_MIN)
    |=> mpu_cfg_pkg::attr_pack(attr_raw[$past(region_select)])
        == $past(wb_req_i.dat & 32'h173F_FF3F))
    else $error("attribute word not stored");

  a_alias_selects: assert property (@(posedge clk_i) disable iff (rst_i)
    take && wb_req_i.we && (wb_req_i.adr == mpu_cfg_pkg::ADR_BASE_A1)
    && base_valid && base_region_ok
    |=> region_select == $past(base_region[IDX_W-1:0]))
    else $error("alias base write did not move select");

  a_unmapped_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_req_i.we && !hit_type && !hit_select && !hit_base && !hit_attr
    |-> wb_dat_o == 32'h0000_0000)
    else $error("unmapped read nonzero");

  a_attr_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_ack_o && !wb_req_i.we && hit_attr
    |-> (wb_dat_o & 32'hE8C0_00C0) == 32'h0000_0000)
    else $error("reserved attribute bits nonzero");

  a_reset_outputs: assert property (@(posedge clk_i)
    rst_i
    |=> !wb_ack_o && (wb_dat_o == 32'h0000_0000) && (region_cfg_o == '0))
    else $error("outputs not cleared by reset");

endmodule : mpu_region_config_bank

// [dv/sw_master.sv]
// Software-side bus master model for the region configuration bank.
// Assumes classic Wishbone on clk_i; the bench calls xfer for each access.
`timescale 1ns/100ps
module sw_master
(
  // Clock
  input  wire logic            clk_i,
  // Wishbone master
  output mpu_cfg_pkg::wb_req_s wb_req_o,
  input  wire logic            wb_ack_i,
  input  wire logic [31:0]     wb_dat_i
);
  // ==========================================================================
  // Bus cycle
  initial wb_req_o = '0;

  // Holds the request until ack is sampled; idle lines carry inverted values
  task automatic xfer(input logic we, input logic [31:0] adr, input logic [31:0] dat,
                      input logic [3:0] sel, output logic [31:0] rd, output logic ok);
    ok = 1'b0;
    rd = 32'h0000_0000;
    @(posedge clk_i);
    wb_req_o <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: sel, adr: adr, dat: dat};
    for (int n = 0; n < 16 && !ok; n++)
    begin
      @(posedge clk_i);
      ok = (wb_ack_i === 1'b1);
    end
    rd = wb_dat_i;
    wb_req_o <= '{cyc: 1'b0, stb: 1'b0, we: ~we, sel: ~sel, adr: ~adr, dat: ~dat};
  endtask : xfer
endmodule : sw_master

// [dv/tb.sv]
// Self-checking bench for the region configuration bank.
// Assumes the software master model and the design package.
`timescale 1ns/100ps
module tb;
  // ==========================================================================
  // Clock, reset and wiring
  logic                           clk_i = 1'b0;
  logic                           rst_i = 1'b1;
  mpu_cfg_pkg::wb_req_s           wb_req;
  logic                           wb_ack;
  logic [31:0]                    wb_dat;
  mpu_cfg_pkg::region_cfg_s [7:0] region_cfg;
  logic [7:0]                     region_active;
  logic [31:0]                    rd;
  int                             bad_count = 0;
  int                             num_checks = 0;

  always #5 clk_i = ~clk_i;

  mpu_region_config_bank u_dut (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .wb_req_i        (wb_req),
    .wb_ack_o        (wb_ack),
    .wb_dat_o        (wb_dat),
    .region_cfg_o    (region_cfg),
    .region_active_o (region_active)
  );

  sw_master u_sw (
    .clk_i    (clk_i),
    .wb_req_o (wb_req),
    .wb_ack_i (wb_ack),
    .wb_dat_i (wb_dat)
  );

  // ==========================================================================
  // Tasks
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic we, input logic [31:0] adr, input logic [31:0] dat,
                     input logic [3:0] sel);
    logic ok;
    u_sw.xfer(we, adr, dat, sel, rd, ok);
    if (!ok)
    begin
      bad_count++;
      $display("[ERR] %0t no bus answer", $time);
      test_done();
    end
  endtask : bus

  task automatic wr(input logic [31:0] adr, input logic [31:0] dat);
    bus(1'b1, adr, dat, 4'hF);
  endtask : wr

  task automatic rdchk(input logic [31:0] adr, input logic [31:0] exp);
    bus(1'b0, adr, 32'h0000_0000, 4'hF);
    check(rd, exp);
  endtask : rdchk

  // Attribute word: fetch disable, perm and type from k, S C B = 001
  function automatic logic [31:0] aw(input int k, input logic [4:0] sz, input logic [7:0] m);
    return {3'h0, k[0], 1'b0, k[2:0], 2'h0, k[2:0], 3'h1, m, 2'h0, sz, 1'b1};
  endfunction : aw

  function automatic logic [31:0] bi(input int k);
    return 32'h2000_0000 | (32'(k) << 10);
  endfunction : bi

  // ==========================================================================
  // Sequence
  initial
  begin
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(mpu_cfg_pkg::ADR_SELECT, 32'h0000_0000);
    rdchk(mpu_cfg_pkg::ADR_ATTR, 32'h0000_0000);
    rdchk(mpu_cfg_pkg::ADR_TYPE, 32'h0000_0800);
    check({24'h0, region_active}, 32'h0000_0000);
    $display("test reset done");
    for (int i = 0; i < 9; i++)
    begin
      wr(mpu_cfg_pkg::ADR_SELECT, 32'(i));
      rdchk(mpu_cfg_pkg::ADR_SELECT, (i < 8) ? 32'(i) : 32'h7);
    end
    $display("test select done");
    for (int i = 0; i < 8; i++)
    begin
      wr(mpu_cfg_pkg::ADR_SELECT, 32'(i));
      wr(i[0] ? mpu_cfg_pkg::ADR_ATTR_A1 : mpu_cfg_pkg::ADR_ATTR, aw(i, 5'h09, 8'(17 * i)));
      if (i[0])
      begin
        wr(mpu_cfg_pkg::ADR_SELECT, 32'h0000_0000);
        wr(mpu_cfg_pkg::ADR_BASE_A1, bi(i) | 32'h10 | 32'(i));
        rdchk(mpu_cfg_pkg::ADR_SELECT, 32'(i));
      end
      else
        wr(mpu_cfg_pkg::ADR_BASE, bi(i) | 32'h7);
      rdchk(i[0] ? mpu_cfg_pkg::ADR_BASE : mpu_cfg_pkg::ADR_BASE_A1, bi(i) | 32'(i));
      rdchk(i[0] ? mpu_cfg_pkg::ADR_ATTR : mpu_cfg_pkg::ADR_ATTR_A1, aw(i, 5'h09, 8'(17 * i)));
    end
    for (int i = 0; i < 8; i++)
    begin
      check(32'(region_cfg[i].attr), {8'h0, i[0], 3'(i), 3'(i), 3'h1,
            8'(17 * i), 5'h09, 1'b1});
      check(region_cfg[i].base, bi(i));
    end
    check({24'h0, region_active}, 32'h0000_00FF);
    $display("test program done");
    wr(mpu_cfg_pkg::ADR_SELECT, 32'h2);
    bus(1'b1, mpu_cfg_pkg::ADR_ATTR, 32'h1000_FFFF, 4'hC);
    rdchk(mpu_cfg_pkg::ADR_ATTR, 32'h1000_0000 | (aw(2, 5'h09, 8'h22) & 32'h0000_FFFF));
    bus(1'b1, mpu_cfg_pkg::ADR_ATTR_A1, 32'hFFFF_0012, 4'h3);
    rdchk(mpu_cfg_pkg::ADR_ATTR, 32'h1000_0012);
    check({24'h0, region_active}, 32'h0000_00FB);
    $display("test halfword done");
    wr(mpu_cfg_pkg::ADR_SELECT, 32'h3);
    wr(mpu_cfg_pkg::ADR_ATTR, 32'h0000_003F);
    rdchk(mpu_cfg_pkg::ADR_BASE, 32'h0000_0003);
    check(region_cfg[3].base, 32'h0000_0000);
    wr(mpu_cfg_pkg::ADR_SELECT, 32'h4);
    wr(mpu_cfg_pkg::ADR_ATTR, 32'h0000_0027);
    rdchk(mpu_cfg_pkg::ADR_BASE, 32'h2000_0004);
    wr(mpu_cfg_pkg::ADR_SELECT, 32'h5);
    wr(mpu_cfg_pkg::ADR_ATTR, 32'h0000_0009);
    wr(mpu_cfg_pkg::ADR_SELECT, 32'h0);
    wr(mpu_cfg_pkg::ADR_BASE, 32'h2000_1475);
    rdchk(mpu_cfg_pkg::ADR_BASE, 32'h2000_1465);
    check(region_cfg[5].base, 32'h2000_1460);
    wr(mpu_cfg_pkg::ADR_BASE, 32'h3000_0018);
    rdchk(mpu_cfg_pkg::ADR_BASE, 32'h2000_1465);
    $display("test size done");
    wr(mpu_cfg_pkg::ADR_TYPE, 32'hFFFF_FFFF);
    rdchk(mpu_cfg_pkg::ADR_TYPE, 32'h0000_0800);
    wr(32'hE000_ED94, 32'hFFFF_FFFF);
    rdchk(32'hE000_ED94, 32'h0000_0000);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    check({24'h0, region_active}, 32'h0000_0000);
    rdchk(mpu_cfg_pkg::ADR_SELECT, 32'h0000_0000);
    rdchk(mpu_cfg_pkg::ADR_ATTR, 32'h0000_0000);
    $display("test rerun reset done");
    test_done();
  end
endmodule : tb
